// ==== include/sfc_consts.vh ====
// Constants for the fractional synthesizer control register slice
`ifndef SFC_CONSTS_VH
`define SFC_CONSTS_VH

// ----------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------
`define SFC_FRAME_BITS 5'h18
`define SFC_HDR_LAST 5'h0F
`define SFC_FRAME_LAST 5'h17
`define SFC_ADDR_W 15
`define SFC_SYNC_STAGES 3

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SFC_OFF_INTEGER_WORD 15'h0010
`define SFC_OFF_FRACTION_MIX 15'h0017
`define SFC_OFF_SECOND_FRACTION_HIGH 15'h0018
`define SFC_OFF_SECOND_MODULUS_LOW 15'h0019
`define SFC_OFF_SECOND_MODULUS_HIGH 15'h001A
`define SFC_OFF_SEED_WORD_LOW 15'h001B
`define SFC_OFF_SEED_WORD_MID 15'h001C
`define SFC_OFF_SEED_WORD_HIGH 15'h001D
`define SFC_OFF_LOOP_CONTROL 15'h001E
`define SFC_BANK_BASE 15'h0017
`define SFC_BANK_LAST 15'h001E
`define SFC_BANK_SIZE 8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SFC_RST_BYTE 8'h00
`define SFC_RST_FRACTION 14'h0000
`define SFC_RST_NONE_READ 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SFC_FRAC_LOW_HI 7
`define SFC_FRAC_LOW_LO 1
`define SFC_FRAC_HIGH_HI 6
`define SFC_MOD_HIGH_HI 5
`define SFC_PUMP_HI 7
`define SFC_PUMP_LO 4
`define SFC_POL_BIT 3
`define SFC_PD_BIT 2
`define SFC_HOLD_BIT 0

`endif

// ==== logic/sfc_spi_slave.v ====
// Serial port slave: pin synchronisers, frame shifter, read-back driver
`timescale 1ns/1ps
`include "sfc_consts.vh"

module sfc_spi_slave (
    // Clock and reset
    input wire mclk,
    input wire rstn,
    input wire ce,
    // Serial pins
    input wire spi_sclk,
    input wire spi_cs_n,
    input wire spi_sdi,
    output reg spi_sdo_q,
    output reg spi_sdo_oe_q,
    // Register side
    output reg wr_stb_q,
    output reg [14:0] wr_addr_q,
    output reg [7:0] wr_data_q,
    output reg [14:0] rd_addr_q,
    input wire [7:0] rd_data
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    wire [2:0] pin_raw;
    wire [2:0] pin_f;
    // Idle levels of sclk, cs_n and sdi; reset to these so no false edge follows reset
    localparam [2:0] pin_idle = 3'h2;
    assign pin_raw = {spi_sclk, spi_cs_n, spi_sdi};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_sync
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg filt_q;
            // Three stages; a change counts once stages two and three agree
            always @(posedge mclk or negedge rstn)
            begin
                if (!rstn)
                begin
                    s1_q <= pin_idle[gi];
                    s2_q <= pin_idle[gi];
                    s3_q <= pin_idle[gi];
                    filt_q <= pin_idle[gi];
                end
                else if (ce)
                begin
                    s1_q <= pin_raw[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q)
                        filt_q <= s3_q;
                end
            end
            assign pin_f[gi] = filt_q;
        end
    endgenerate

    wire sclk_f;
    wire cs_n_f;
    wire sdi_f;
    assign sclk_f = pin_f[2];
    assign cs_n_f = pin_f[1];
    assign sdi_f = pin_f[0];

    // ----------------------------------------------------------------
    // Frame shifter
    // ----------------------------------------------------------------
    reg sclk_d_q;
    reg [23:0] shift_q;
    reg [4:0] count_q;
    reg reading_q;
    reg [2:0] out_idx_q;
    wire rise;
    wire fall;
    wire [23:0] shift_d;
    assign rise = sclk_f & ~sclk_d_q & ~cs_n_f;
    assign fall = ~sclk_f & sclk_d_q & ~cs_n_f;
    assign shift_d = {shift_q[22:0], sdi_f};

    // Collect read/write flag, address and data on rising clock edges
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            sclk_d_q <= 1'b0;
            shift_q <= 24'h00_0000;
            count_q <= 5'h00;
            reading_q <= 1'b0;
            out_idx_q <= 3'h0;
            wr_stb_q <= 1'b0;
            wr_addr_q <= 15'h0000;
            wr_data_q <= 8'h00;
            rd_addr_q <= 15'h0000;
            spi_sdo_q <= 1'b0;
            spi_sdo_oe_q <= 1'b0;
        end
        else if (ce)
        begin
            sclk_d_q <= sclk_f;
            wr_stb_q <= 1'b0;
            spi_sdo_oe_q <= reading_q & ~cs_n_f;
            if (cs_n_f)
            begin
                count_q <= 5'h00;
                reading_q <= 1'b0;
                out_idx_q <= 3'h0;
            end
            else if (rise && count_q < `SFC_FRAME_BITS)
            begin
                shift_q <= shift_d;
                count_q <= count_q + 5'h01;
                if (count_q == `SFC_HDR_LAST)
                begin
                    reading_q <= shift_d[15];
                    rd_addr_q <= shift_d[14:0];
                end
                if (count_q == `SFC_FRAME_LAST && !reading_q)
                begin
                    wr_stb_q <= 1'b1;
                    wr_addr_q <= shift_d[22:8];
                    wr_data_q <= shift_d[7:0];
                end
            end
            // Read data leaves MSB first on falling edges
            if (fall && reading_q)
            begin
                spi_sdo_q <= rd_data[3'h7 - out_idx_q];
                out_idx_q <= out_idx_q + 3'h1;
            end
        end
    end

endmodule // sfc_spi_slave

// ==== logic/sfc_ctrl_regs.v ====
// Control register slice of the fractional-N synthesizer
`timescale 1ns/1ps
`include "sfc_consts.vh"
//
// Contract
// - Register 0x018 bits 6:0 hold second fraction bits 13:7; bit 7 reserved.
// - Second modulus from 0x019 low byte and 0x01A bits 5:0.
// - Pump current code in 0x01E bits 7:4, 0.35 mA steps.
// - Bit 3 of 0x01E sets detector polarity; 1 positive, 0 negative.
// - Bit 2 of 0x01E powers down loop blocks only.
// - Power-down never clears stored register contents.
// - Bit 0 of 0x01E holds both divider counters in reset.
// - No divider edges reach the detector while counters are held.
// - Registers 0x018 through 0x01E reset to 0x00.
// - Fraction and modulus take effect only on a 0x010 write.
// - Register 0x017 bits 7:1 hold second fraction bits 6:0.

module sfc_ctrl_regs (
    // Clock, enable and reset
    input wire mclk,
    input wire rstn,
    input wire ce,
    // Serial port pins
    input wire spi_sclk,
    input wire spi_cs_n,
    input wire spi_sdi,
    output wire spi_sdo,
    output wire spi_sdo_oe,
    // Divider edges in
    input wire fb_div_edge,
    input wire ref_div_edge,
    // Divider edges to the phase detector
    output reg pfd_fb_edge_q,
    output reg pfd_ref_edge_q,
    // Applied divide ratio fractions
    output reg [13:0] second_fraction_q,
    output reg [13:0] second_modulus_q,
    output reg apply_stb_q,
    // Loop settings
    output reg [23:0] phase_seed_q,
    output reg [3:0] pump_current_code_q,
    output reg detector_polarity_q,
    output reg synth_power_down_q,
    output reg divider_hold_q,
    output reg first_fraction_top_q
);

    // ----------------------------------------------------------------
    // Serial port
    // ----------------------------------------------------------------
    wire wr_stb;
    wire [14:0] wr_addr;
    wire [7:0] wr_data;
    wire [14:0] rd_addr;
    reg [7:0] rd_data;

    sfc_spi_slave u_spi (
        .mclk(mclk),
        .rstn(rstn),
        .ce(ce),
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_sdi(spi_sdi),
        .spi_sdo_q(spi_sdo),
        .spi_sdo_oe_q(spi_sdo_oe),
        .wr_stb_q(wr_stb),
        .wr_addr_q(wr_addr),
        .wr_data_q(wr_data),
        .rd_addr_q(rd_addr),
        .rd_data(rd_data)
    );

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // True when the address falls inside the held bank
    function in_bank;
        input [14:0] addr;
        begin
            in_bank = (addr >= `SFC_BANK_BASE) && (addr <= `SFC_BANK_LAST);
        end
    endfunction

    // Bank slot of an address inside the bank
    function [2:0] bank_slot;
        input [14:0] addr;
        reg [14:0] diff;
        begin
            diff = addr - `SFC_BANK_BASE;
            bank_slot = diff[2:0];
        end
    endfunction

    // ----------------------------------------------------------------
    // Register bank 0x017..0x01E
    // ----------------------------------------------------------------
    wire [7:0] bank [0:`SFC_BANK_SIZE-1];

    genvar gi;
    generate
        for (gi = 0; gi < `SFC_BANK_SIZE; gi = gi + 1)
        begin : g_bank
            reg [7:0] byte_q;
            // Byte register; nothing but a host write changes it
            always @(posedge mclk or negedge rstn)
            begin
                if (!rstn)
                    byte_q <= `SFC_RST_BYTE;
                else if (ce && wr_stb && in_bank(wr_addr) && bank_slot(wr_addr) == gi)
                    byte_q <= wr_data;
            end
            assign bank[gi] = byte_q;
        end
    endgenerate

    wire [7:0] reg_frac_mix;
    wire [7:0] reg_frac_high;
    wire [7:0] reg_mod_low;
    wire [7:0] reg_mod_high;
    wire [7:0] reg_seed_low;
    wire [7:0] reg_seed_mid;
    wire [7:0] reg_seed_high;
    wire [7:0] reg_loop;
    assign reg_frac_mix = bank[0];
    assign reg_frac_high = bank[1];
    assign reg_mod_low = bank[2];
    assign reg_mod_high = bank[3];
    assign reg_seed_low = bank[4];
    assign reg_seed_mid = bank[5];
    assign reg_seed_high = bank[6];
    assign reg_loop = bank[7];

    // Read-back: held bytes, all other addresses read zero
    always @*
    begin
        if (in_bank(rd_addr))
            rd_data = bank[bank_slot(rd_addr)];
        else
            rd_data = `SFC_RST_NONE_READ;
    end

    // ----------------------------------------------------------------
    // Staged fraction and modulus
    // ----------------------------------------------------------------
    wire [13:0] staged_fraction;
    wire [13:0] staged_modulus;
    wire integer_write;
    // Upper bits from 0x018, lower bits from 0x017
    assign staged_fraction = {reg_frac_high[`SFC_FRAC_HIGH_HI:0],
                              reg_frac_mix[`SFC_FRAC_LOW_HI:`SFC_FRAC_LOW_LO]};
    // Upper six bits from 0x01A, low byte from 0x019
    assign staged_modulus = {reg_mod_high[`SFC_MOD_HIGH_HI:0], reg_mod_low};
    assign integer_write = wr_stb && (wr_addr == `SFC_OFF_INTEGER_WORD);

    // Apply staged values only when the integer word is written
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            second_fraction_q <= `SFC_RST_FRACTION;
            second_modulus_q <= `SFC_RST_FRACTION;
            apply_stb_q <= 1'b0;
        end
        else if (ce)
        begin
            apply_stb_q <= integer_write;
            if (integer_write)
            begin
                second_fraction_q <= staged_fraction;
                second_modulus_q <= staged_modulus;
            end
        end
    end

    // ----------------------------------------------------------------
    // Loop settings
    // ----------------------------------------------------------------
    // Registered copies of the direct control fields
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase_seed_q <= 24'h00_0000;
            pump_current_code_q <= 4'h0;
            detector_polarity_q <= 1'b0;
            synth_power_down_q <= 1'b0;
            divider_hold_q <= 1'b0;
            first_fraction_top_q <= 1'b0;
        end
        else if (ce)
        begin
            phase_seed_q <= {reg_seed_high, reg_seed_mid, reg_seed_low};
            pump_current_code_q <= reg_loop[`SFC_PUMP_HI:`SFC_PUMP_LO];
            detector_polarity_q <= reg_loop[`SFC_POL_BIT];
            synth_power_down_q <= reg_loop[`SFC_PD_BIT];
            divider_hold_q <= reg_loop[`SFC_HOLD_BIT];
            first_fraction_top_q <= reg_frac_mix[0];
        end
    end

    // ----------------------------------------------------------------
    // Divider edge gate
    // ----------------------------------------------------------------
    // Edges pass only while the counters run
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            pfd_fb_edge_q <= 1'b0;
            pfd_ref_edge_q <= 1'b0;
        end
        else if (ce)
        begin
            pfd_fb_edge_q <= fb_div_edge & ~reg_loop[`SFC_HOLD_BIT];
            pfd_ref_edge_q <= ref_div_edge & ~reg_loop[`SFC_HOLD_BIT];
        end
    end

endmodule // sfc_ctrl_regs

// ==== bench/sfc_ctrl_regs_checker.sv ====
// Port-level assertions for the synthesizer control register slice
`timescale 1ns/1ps

module sfc_ctrl_regs_checker (
    // Clock, enable and reset
    input wire mclk,
    input wire rstn,
    input wire ce,
    // Serial pins
    input wire spi_sclk,
    input wire spi_cs_n,
    input wire spi_sdi,
    input wire spi_sdo,
    input wire spi_sdo_oe,
    // Divider edges
    input wire fb_div_edge,
    input wire ref_div_edge,
    input wire pfd_fb_edge_q,
    input wire pfd_ref_edge_q,
    // Settings
    input wire [13:0] second_fraction_q,
    input wire [13:0] second_modulus_q,
    input wire apply_stb_q,
    input wire [23:0] phase_seed_q,
    input wire [3:0] pump_current_code_q,
    input wire detector_polarity_q,
    input wire synth_power_down_q,
    input wire divider_hold_q,
    input wire first_fraction_top_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    // Chip select idle long enough for any write to have landed
    sequence s_idle;
        spi_cs_n [*8] ##1 spi_cs_n;
    endsequence

    chk_fb_blocked: assert property (pfd_fb_edge_q |-> !divider_hold_q)
        else $error("feedback edge passed while counters held");
    chk_ref_blocked: assert property (pfd_ref_edge_q |-> !divider_hold_q)
        else $error("reference edge passed while counters held");
    chk_fb_pass: assert property ($past(fb_div_edge) && $past(ce) && !divider_hold_q |-> pfd_fb_edge_q)
        else $error("feedback edge lost in normal counting");
    chk_ref_pass: assert property ($past(ref_div_edge) && $past(ce) && !divider_hold_q |-> pfd_ref_edge_q)
        else $error("reference edge lost in normal counting");
    chk_apply_once: assert property (apply_stb_q |=> !apply_stb_q)
        else $error("apply strobe longer than one cycle");
    chk_ratio_held: assert property (!apply_stb_q && $past(rstn) |->
        $stable(second_fraction_q) && $stable(second_modulus_q))
        else $error("ratio changed without apply");
    chk_oe_idle: assert property (s_idle |-> !spi_sdo_oe)
        else $error("read driver enabled while deselected");
    chk_settings_quiet: assert property (s_idle |-> $stable(phase_seed_q) &&
        $stable(pump_current_code_q) && $stable(divider_hold_q))
        else $error("setting changed with no frame");
endmodule // sfc_ctrl_regs_checker

bind sfc_ctrl_regs sfc_ctrl_regs_checker sfc_ctrl_regs_checker_inst (.mclk, .rstn, .ce, .spi_sclk, .spi_cs_n,
    .spi_sdi, .spi_sdo, .spi_sdo_oe, .fb_div_edge, .ref_div_edge, .pfd_fb_edge_q, .pfd_ref_edge_q,
    .second_fraction_q, .second_modulus_q, .apply_stb_q, .phase_seed_q, .pump_current_code_q,
    .detector_polarity_q, .synth_power_down_q, .divider_hold_q, .first_fraction_top_q);

// ==== bench/sfc_spi_host.sv ====
// Serial port host model: mode 0, MSB first, 24-bit frames
`timescale 1ns/1ps

module sfc_spi_host (
    // Clock
    input wire mclk,
    // Serial pins
    output reg sclk,
    output reg cs_n,
    output reg sdi,
    input wire sdo
);
    reg busy = 1'b0;

    // Idle pins at time zero
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    // Data line toggles outside frames so a stale level is never read
    always @(posedge mclk)
        if (!busy)
            sdi <= ~sdi;

    // One frame; each sclk level held six cycles
    task automatic xfer(input reg rw, input reg [14:0] a, input reg [7:0] wd, output reg [7:0] rq);
        reg [23:0] f;
        integer i;
        begin
            f = {rw, a, wd};
            rq = 8'h00;
            busy = 1'b1;
            @(posedge mclk);
            cs_n <= 1'b0;
            for (i = 23; i >= 0; i = i - 1)
            begin
                sdi <= f[i];
                repeat (6) @(posedge mclk);
                if (i < 8)
                    rq[i] = sdo; // Read bit taken at the rise
                sclk <= 1'b1;
                repeat (6) @(posedge mclk);
                sclk <= 1'b0;
            end
            repeat (6) @(posedge mclk);
            cs_n <= 1'b1;
            busy = 1'b0;
            repeat (9) @(posedge mclk);
        end
    endtask
endmodule // sfc_spi_host

// ==== bench/test_sfc_ctrl_regs.sv ====
// Self-checking testbench for the synthesizer control register slice
`timescale 1ns/1ps

module test_sfc_ctrl_regs;
    reg mclk = 1'b0;
    reg rstn = 1'b0;
    reg ce = 1'b1;
    reg fb_div_edge = 1'b0;
    reg ref_div_edge = 1'b0;
    wire spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe, pfd_fb_edge_q, pfd_ref_edge_q, apply_stb_q;
    wire [13:0] second_fraction_q, second_modulus_q;
    wire [23:0] phase_seed_q;
    wire [3:0] pump_current_code_q;
    wire detector_polarity_q, synth_power_down_q, divider_hold_q, first_fraction_top_q;
    wire sdo_pin;
    integer errors = 0;
    integer samples_checked = 0;
    integer i;
    reg [7:0] rdat;

    // 125 MHz clock
    always #4 mclk = ~mclk;

    sfc_ctrl_regs sfc_ctrl_regs_inst (.mclk, .rstn, .ce, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo, .spi_sdo_oe,
        .fb_div_edge, .ref_div_edge, .pfd_fb_edge_q, .pfd_ref_edge_q, .second_fraction_q, .second_modulus_q,
        .apply_stb_q, .phase_seed_q, .pump_current_code_q, .detector_polarity_q, .synth_power_down_q,
        .divider_hold_q, .first_fraction_top_q);
    // Released read line shows the inverse, so a missing enable corrupts read data
    assign sdo_pin = spi_sdo_oe ? spi_sdo : ~spi_sdo;
    sfc_spi_host sfc_spi_host_inst (.mclk(mclk), .sclk(spi_sclk), .cs_n(spi_cs_n), .sdi(spi_sdi), .sdo(sdo_pin));

    task check(input reg [23:0] seen, input reg [23:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp)
            begin
                errors = errors + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task end_sim;
        begin
            $display("errors %0d samples_checked %0d", errors, samples_checked);
            if (errors == 0 && samples_checked > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    task wr(input reg [14:0] a, input reg [7:0] d);
        sfc_spi_host_inst.xfer(1'b0, a, d, rdat);
    endtask

    task rd(input reg [14:0] a, input reg [7:0] exp);
        begin
            sfc_spi_host_inst.xfer(1'b1, a, 8'h00, rdat);
            check(24'(rdat), 24'(exp));
        end
    endtask

    // Pulse both divider edges once and count what reaches the detector
    task pulse(output reg [7:0] n);
        begin
            n = 8'h00;
            @(posedge mclk);
            fb_div_edge <= 1'b1;
            ref_div_edge <= 1'b1;
            repeat (3)
            begin
                @(posedge mclk);
                fb_div_edge <= 1'b0;
                ref_div_edge <= 1'b0;
                #1 n = n + {7'h00, pfd_fb_edge_q} + {7'h00, pfd_ref_edge_q};
            end
        end
    endtask

    // Reset values, then an unmapped place
    task t_reset;
        begin
            for (i = 24; i <= 30; i = i + 1)
                rd(i[14:0], 8'h00);
            check(24'({pump_current_code_q, detector_polarity_q, divider_hold_q}), 24'h00_0000);
            wr(15'h0030, 8'hFF);
            rd(15'h0030, 8'h00);
        end
    endtask

    // Staged fraction and modulus move only on an integer word write
    task t_ratio;
        begin
            wr(15'h0017, 8'hAB);
            wr(15'h0018, 8'h55);
            wr(15'h0019, 8'h34);
            wr(15'h001A, 8'h3F);
            rd(15'h0018, 8'h55);
            check(24'(second_fraction_q), 24'h00_0000);
            wr(15'h0010, 8'h80);
            check(24'(second_fraction_q), 24'h00_2AD5);
            check(24'(second_modulus_q), 24'h00_3F34);
            check(24'(first_fraction_top_q), 24'h00_0001);
        end
    endtask

    // Recommended seed spread over three bytes
    task t_seed;
        begin
            wr(15'h001B, 8'h09);
            wr(15'h001C, 8'h00);
            wr(15'h001D, 8'h80);
            check(phase_seed_q, 24'h80_0009);
        end
    endtask

    // Every pump code with positive polarity
    task t_pump;
        for (i = 0; i < 16; i = i + 1)
        begin
            wr(15'h001E, {i[3:0], 4'h8});
            check(24'({pump_current_code_q, detector_polarity_q}), 24'({i[3:0], 1'b1}));
        end
    endtask

    // Held counters block edges; power-down keeps stored words
    task t_hold;
        begin
            wr(15'h001E, 8'h05);
            check(24'({synth_power_down_q, divider_hold_q}), 24'h00_0003);
            pulse(rdat);
            check(24'(rdat), 24'h00_0000);
            rd(15'h001B, 8'h09);
            check(24'(second_modulus_q), 24'h00_3F34);
            wr(15'h001E, 8'h00);
            wr(15'h0010, 8'h80);
            pulse(rdat);
            check(24'(rdat), 24'h00_0002);
            // With the clock enable low the gate is frozen and passes nothing
            @(posedge mclk);
            ce <= 1'b0;
            pulse(rdat);
            @(posedge mclk);
            ce <= 1'b1;
            check(24'(rdat), 24'h00_0000);
        end
    endtask

    // Hang guard
    initial
    begin
        #400000;
        errors = errors + 1;
        end_sim;
    end

    // Main sequence
    initial
    begin
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        repeat (10) @(posedge mclk);
        t_reset;
        t_ratio;
        t_seed;
        t_pump;
        t_hold;
        end_sim;
    end
endmodule // test_sfc_ctrl_regs
